// ---- pkg/serial_port_pkg.sv ----
// Constants, field layouts and state codes of the serial port block.
// Assumes a single system clock; the shift rates count in its cycles.
//
// Functional notes
// RULE1 - Buffer writes load transmit data; reads return receive buffer.
// RULE2 - Shift mode: data both ways on receive pin, clock on transmit pin.
// RULE3 - Shift mode frames are eight bits, least significant bit first.
// RULE4 - Shift rate is clock/12 with speed select 0, clock/4 with 1.
// RULE5 - Fast rate: data one clock before falling edge, clock low two clocks.
// RULE6 - Slow rate: data three clocks before fall, clock low six clocks.
// RULE7 - Any serial_buffer write starts a transmission of all eight bits; a write while a start is still pending replaces its data instead.
// RULE8 - Synchronous transmit done flag set in the phase after the last bit.
// RULE9 - Shift receive starts if enabled, flag clear; latch at clock rise.
// RULE10 - External device changes receive data at shift clock falling edge.
// RULE11 - Receive flag set after last rise; no reception until cleared.
// RULE12 - Async frame: start 0, eight data bits LSB first, stop 1.
// RULE13 - Async bit rate is timer overflow rate divided by 16 or 32.
// RULE14 - Async transmit bits follow divide-by-16 rollovers, not the write.
// RULE15 - Async transmit flag set as the stop bit starts, tenth rollover after write.
// RULE16 - Receiver samples at 16x bit rate; falling edge resets its counter.
// RULE17 - Each received bit is a 2-of-3 vote of states eight, nine, ten; the code votes counter values 7, 8 and 9.
// RULE18 - A start bit voted as 1 aborts reception; edge search resumes.
// RULE19 - Frame kept only if flag clear and speed select 0 or stop 1.
// RULE20 - Accepted stop bit is stored in ninth_received_bit with the data.
// RULE21 - After mid stop bit the receiver watches again for a falling edge.
// RULE22 - Async transmit pin idles high between frames.

package serial_port_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_SERIAL_BUFFER = 8'h04;
	localparam logic [7:0] ADDR_BAUD_CONTROL = 8'h08;

	// ----------------------------------------
	// Reset values and word transfer size
	// ----------------------------------------
	localparam logic [7:0] SERIAL_CONTROL_RST = 8'h00;
	localparam logic [7:0] BAUD_RELOAD_RST = 8'h00;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// ----------------------------------------
	// Synchronous mode timing, in clock cycles
	// ----------------------------------------
	localparam logic [3:0] M0_SLOW_PERIOD = 4'hc;
	localparam logic [3:0] M0_SLOW_LEAD = 4'h3;
	localparam logic [3:0] M0_SLOW_LOW = 4'h6;
	localparam logic [3:0] M0_FAST_PERIOD = 4'h4;
	localparam logic [3:0] M0_FAST_LEAD = 4'h1;
	localparam logic [3:0] M0_FAST_LOW = 4'h2;
	localparam logic [2:0] M0_LAST_BIT = 3'h7;

	// ----------------------------------------
	// Asynchronous mode counts
	// ----------------------------------------
	localparam logic [3:0] DIV16_LAST = 4'hf;
	localparam logic [3:0] VOTE_FIRST = 4'h7;
	localparam logic [3:0] VOTE_LAST = 4'h9;
	localparam logic [3:0] FRAME_LAST = 4'h9;

	// Serial control layout, bit 7 down to bit 0
	typedef struct packed {
		logic async_mode;
		logic spare6;
		logic multiproc_speed_select;
		logic receive_enable;
		logic spare3;
		logic ninth_received_bit;
		logic transmit_done_flag;
		logic receive_done_flag;
	} serial_control_t;

	typedef enum logic [1:0] {
		M0_IDLE = 2'b00,
		M0_TX = 2'b01,
		M0_RX = 2'b10
	} m0_state_t;

	typedef enum logic {
		R_HUNT = 1'b0,
		R_BITS = 1'b1
	} rx1_state_t;

endpackage

// ---- rtl/sync_2ff.sv ----
// Two-flop synchroniser for levels entering from outside the clock domain.
// Assumes the input changes slowly relative to the clock.

module sync_2ff #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Level in and out
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= '1;
			q_o <= '1;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end

endmodule

// ---- rtl/serial_port.sv ----
// Serial port with synchronous shift mode and asynchronous 10-bit mode,
// registers on an AHB-Lite slave.
// Assumes a single clock; the receive pin arrives from outside the domain.

module serial_port
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Serial pins
	input wire logic rxd_i,
	output logic rxd_o,
	output logic rxd_oe_o,
	output logic txd_o
);

	import serial_port_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	serial_control_t serial_control_r;
	logic [7:0] tx_data_r, rx_buf_r, reload_r, wr_addr_r;
	logic half_rate_r, tx_pend_r, wr_pend_r, rxd_s, take;
	logic [31:0] rdata_r;
	logic wr_serial_control, wr_serial_buffer, wr_baud, m0_take, m1_take, ti_set, ri_set;
	m0_state_t m0_state_r;
	logic [3:0] m0_phase_r, m0_period, m0_lead, m0_rise, m0_nph;
	logic [2:0] m0_bit_r;
	logic [7:0] m0_shift_r;
	logic m0_sclk_r, m0_out_r, m0_oe_r, m0_ti_r, m0_ri_r;
	logic [7:0] ovf_cnt_r;
	logic half_r, ovf, tick16, tx_roll, tx1_busy_r, tx1_line_r, m1_ti_r;
	logic [3:0] tx_div_r, tx1_cnt_r;
	logic [9:0] tx1_frame_r;
	rx1_state_t rx1_state_r;
	logic [3:0] rx_div_r, rx_bit_r;
	logic [1:0] votes_r;
	logic [7:0] rx1_shift_r, m1_data_r;
	logic rxd_prev_r, fall, vote, vote_now, m1_acc_r, m1_stop_r;

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	sync_2ff #(.WIDTH(1)) u_rxd_sync (
		.clk_i(clk_i), .rst_i(rst_i), .d_i(rxd_i), .q_o(rxd_s)
	);

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	// Zero wait states, always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign hrdata_o = rdata_r;
	assign take = hsel_i & hready_i & htrans_i[1];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= take & hwrite_i & (hsize_i == HSIZE_WORD);
			wr_addr_r <= haddr_i[7:0];
		end
	end

	assign wr_serial_control = wr_pend_r & (wr_addr_r == ADDR_SERIAL_CONTROL);
	assign wr_serial_buffer = wr_pend_r & (wr_addr_r == ADDR_SERIAL_BUFFER);
	assign wr_baud = wr_pend_r & (wr_addr_r == ADDR_BAUD_CONTROL);

	// Read data sampled in the address phase; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_r <= 32'h0000_0000;
		end else if (take & ~hwrite_i) begin
			case (haddr_i[7:0])
				ADDR_SERIAL_CONTROL: rdata_r <= {24'h00_0000, serial_control_r};
				ADDR_SERIAL_BUFFER: rdata_r <= {24'h00_0000, rx_buf_r}; // [RULE1]
				ADDR_BAUD_CONTROL: rdata_r <= {23'h00_0000, half_rate_r, reload_r};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	assign ti_set = m0_ti_r | m1_ti_r;
	assign ri_set = m0_ri_r | m1_acc_r;

	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_control_r <= SERIAL_CONTROL_RST;
		end else begin
			if (wr_serial_control) begin
				serial_control_r <= hwdata_i[7:0];
			end
			if (ti_set) begin
				serial_control_r.transmit_done_flag <= 1'b1;
			end
			if (ri_set) begin
				serial_control_r.receive_done_flag <= 1'b1;
			end
			if (m1_acc_r) begin
				serial_control_r.ninth_received_bit <= m1_stop_r; // [RULE20]
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reload_r <= BAUD_RELOAD_RST;
			half_rate_r <= 1'b0;
		end else if (wr_baud) begin
			reload_r <= hwdata_i[7:0];
			half_rate_r <= hwdata_i[8];
		end
	end

	// Transmit register; a new write overrides a pending start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_data_r <= 8'h00;
			tx_pend_r <= 1'b0;
		end else if (wr_serial_buffer) begin
			tx_data_r <= hwdata_i[7:0]; // [RULE1]
			tx_pend_r <= 1'b1; // [RULE7]
		end else if (m0_take | m1_take) begin
			tx_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_buf_r <= 8'h00;
		end else if (m0_ri_r) begin
			rx_buf_r <= m0_shift_r;
		end else if (m1_acc_r) begin
			rx_buf_r <= m1_data_r; // [RULE20]
		end
	end

	// ----------------------------------------
	// Synchronous shift mode
	// ----------------------------------------
	assign m0_period = serial_control_r.multiproc_speed_select ? M0_FAST_PERIOD
		: M0_SLOW_PERIOD; // [RULE4]
	assign m0_lead = serial_control_r.multiproc_speed_select ? M0_FAST_LEAD : M0_SLOW_LEAD;
	assign m0_rise = m0_lead + (serial_control_r.multiproc_speed_select ? M0_FAST_LOW
		: M0_SLOW_LOW);
	assign m0_nph = m0_phase_r + 4'h1;
	assign m0_take = (m0_state_r == M0_IDLE) & ~serial_control_r.async_mode
		& tx_pend_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			m0_state_r <= M0_IDLE;
			m0_phase_r <= 4'h0;
			m0_bit_r <= 3'h0;
			m0_shift_r <= 8'h00;
			m0_sclk_r <= 1'b1;
			m0_out_r <= 1'b1;
			m0_oe_r <= 1'b0;
			m0_ti_r <= 1'b0;
			m0_ri_r <= 1'b0;
		end else begin
			m0_ti_r <= 1'b0;
			m0_ri_r <= 1'b0;
			case (m0_state_r)
				M0_IDLE: begin
					m0_sclk_r <= 1'b1;
					m0_phase_r <= 4'h0;
					m0_bit_r <= 3'h0;
					if (m0_take) begin
						m0_state_r <= M0_TX; // [RULE7]
						m0_shift_r <= tx_data_r;
						m0_out_r <= tx_data_r[0]; // [RULE3]
						m0_oe_r <= 1'b1; // [RULE2]
					end else if (~serial_control_r.async_mode & serial_control_r.receive_enable
						& ~serial_control_r.receive_done_flag & ~m0_ri_r) begin
						m0_state_r <= M0_RX; // [RULE9] [RULE11]
						m0_oe_r <= 1'b0;
					end
				end
				M0_TX, M0_RX: begin
					// Clock low from lead to rise within each bit
					if (m0_nph == m0_period) begin
						m0_phase_r <= 4'h0;
						m0_sclk_r <= 1'b1;
						if (m0_bit_r == M0_LAST_BIT) begin
							m0_state_r <= M0_IDLE;
							m0_oe_r <= 1'b0;
							m0_ti_r <= (m0_state_r == M0_TX); // [RULE8]
							m0_ri_r <= (m0_state_r == M0_RX); // [RULE11]
						end else begin
							m0_bit_r <= m0_bit_r + 3'h1;
							if (m0_state_r == M0_TX) begin
								m0_shift_r <= {1'b0, m0_shift_r[7:1]};
								m0_out_r <= m0_shift_r[1]; // [RULE3]
							end
						end
					end else begin
						m0_phase_r <= m0_nph;
						m0_sclk_r <= ~((m0_nph >= m0_lead)
							& (m0_nph < m0_rise)); // [RULE5] [RULE6]
						// Latch as the clock goes back high
						if ((m0_state_r == M0_RX) & (m0_nph == m0_rise)) begin
							m0_shift_r <= {rxd_s, m0_shift_r[7:1]}; // [RULE9]
						end
					end
				end
				default: begin
					m0_state_r <= M0_IDLE;
					m0_oe_r <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Baud ticks for the asynchronous mode
	// ----------------------------------------
	// Overflow every reload+1 clocks stands in for the timer
	assign ovf = (ovf_cnt_r == 8'h00);
	assign tick16 = ovf & (~half_rate_r | half_r); // [RULE13]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovf_cnt_r <= BAUD_RELOAD_RST;
			half_r <= 1'b0;
		end else if (ovf) begin
			ovf_cnt_r <= reload_r;
			half_r <= ~half_r;
		end else begin
			ovf_cnt_r <= ovf_cnt_r - 8'h01;
		end
	end

	// ----------------------------------------
	// Asynchronous transmitter
	// ----------------------------------------
	// Free-running, so the start bit waits for the next rollover
	assign tx_roll = tick16 & (tx_div_r == DIV16_LAST);
	assign m1_take = serial_control_r.async_mode & tx_roll & ~tx1_busy_r & tx_pend_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_div_r <= 4'h0;
		end else if (tick16) begin
			tx_div_r <= tx_div_r + 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx1_frame_r <= 10'h3ff;
			tx1_cnt_r <= 4'h0;
			tx1_busy_r <= 1'b0;
			tx1_line_r <= 1'b1;
			m1_ti_r <= 1'b0;
		end else begin
			m1_ti_r <= 1'b0;
			if (m1_take) begin
				tx1_frame_r <= {1'b1, tx_data_r, 1'b0}; // [RULE12]
				tx1_line_r <= 1'b0; // [RULE14]
				tx1_cnt_r <= 4'h1;
				tx1_busy_r <= 1'b1;
			end else if (tx1_busy_r & tx_roll) begin
				tx1_line_r <= tx1_frame_r[tx1_cnt_r]; // [RULE14]
				tx1_cnt_r <= tx1_cnt_r + 4'h1;
				if (tx1_cnt_r == FRAME_LAST) begin
					tx1_busy_r <= 1'b0;
					m1_ti_r <= 1'b1; // [RULE15]
				end
			end else if (~tx1_busy_r) begin
				tx1_line_r <= 1'b1; // [RULE22]
			end
		end
	end

	// ----------------------------------------
	// Asynchronous receiver
	// ----------------------------------------
	assign fall = tick16 & rxd_prev_r & ~rxd_s;
	assign vote_now = tick16 & (rx_div_r == VOTE_LAST);
	assign vote = (votes_r[1] & votes_r[0]) | (votes_r[1] & rxd_s)
		| (votes_r[0] & rxd_s); // [RULE17]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rxd_prev_r <= 1'b1;
		end else if (tick16) begin
			rxd_prev_r <= rxd_s; // [RULE16]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx1_state_r <= R_HUNT;
			rx_div_r <= 4'h0;
			rx_bit_r <= 4'h0;
			votes_r <= 2'b00;
			rx1_shift_r <= 8'h00;
			m1_acc_r <= 1'b0;
			m1_data_r <= 8'h00;
			m1_stop_r <= 1'b0;
		end else begin
			m1_acc_r <= 1'b0;
			case (rx1_state_r)
				R_HUNT: begin
					if (fall & serial_control_r.async_mode & serial_control_r.receive_enable) begin
						rx1_state_r <= R_BITS;
						rx_div_r <= 4'h0; // [RULE16]
						rx_bit_r <= 4'h0;
					end
				end
				R_BITS: begin
					if (tick16) begin
						rx_div_r <= rx_div_r + 4'h1;
						if ((rx_div_r >= VOTE_FIRST) & (rx_div_r < VOTE_LAST)) begin
							votes_r <= {votes_r[0], rxd_s}; // [RULE17]
						end
					end
					if (vote_now) begin
						rx_bit_r <= rx_bit_r + 4'h1;
						if (rx_bit_r == 4'h0) begin
							if (vote) begin
								rx1_state_r <= R_HUNT; // [RULE18]
							end
						end else if (rx_bit_r == FRAME_LAST) begin
							// Mid stop bit: decide, then hunt again
							rx1_state_r <= R_HUNT; // [RULE21]
							m1_data_r <= rx1_shift_r;
							m1_stop_r <= vote;
							m1_acc_r <= ~serial_control_r.receive_done_flag
								& (~serial_control_r.multiproc_speed_select | vote); // [RULE19]
						end else begin
							rx1_shift_r <= {vote, rx1_shift_r[7:1]}; // [RULE12]
						end
					end
				end
				default: rx1_state_r <= R_HUNT;
			endcase
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	assign txd_o = serial_control_r.async_mode ? tx1_line_r : m0_sclk_r; // [RULE2]
	assign rxd_o = m0_out_r;
	assign rxd_oe_o = m0_oe_r & ~serial_control_r.async_mode;

endmodule

// ---- bench/serial_port_checker.sv ----
// Pin and bus checks of the serial port.
// Assumes the one clock and synchronous reset of the port.
module serial_port_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic rxd_o,
	input wire logic rxd_oe_o,
	input wire logic txd_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence low_two;
		!txd_o ##1 !txd_o;
	endsequence
	AST_READY: assert property (hreadyout_o && !hresp_o)
		else $error("bus answer not ready okay");
	AST_UPPER: assert property (hrdata_o[31:9] == 23'h0)
		else $error("read data upper bits set");
	AST_RST_IDLE: assert property ($fell(rst_i)
		|-> txd_o && !rxd_oe_o)
		else $error("pins not idle after reset");
	AST_OE_CLK: assert property ($rose(rxd_oe_o) |-> txd_o)
		else $error("frame starts with clock low");
	AST_LOW_MIN: assert property (rxd_oe_o && $fell(txd_o) |-> low_two)
		else $error("shift clock low too short");
	AST_LOW_MAX: assert property (rxd_oe_o && $fell(txd_o)
		|-> ##[1:6] txd_o)
		else $error("shift clock low too long");
	AST_DATA_HOLD: assert property (rxd_oe_o && $past(rxd_oe_o)
		&& $changed(rxd_o) |-> txd_o && $past(txd_o))
		else $error("data moved while clock low");
	AST_OE_END: assert property ($fell(rxd_oe_o) |-> txd_o)
		else $error("frame ends with clock low");
endmodule

bind serial_port serial_port_checker chk_u (.clk_i, .rst_i, .hrdata_o,
	.hreadyout_o, .hresp_o, .rxd_o, .rxd_oe_o, .txd_o);

// ---- bench/serial_peer.sv ----
// Remote shift device and remote serial sender on the port pins.
// Assumes a pulled-up receive line; released means high.
module serial_peer (
	input wire logic clk_i,
	input wire logic txd_i,
	input wire logic rxd_oe_i,
	input wire logic rxd_i,
	output logic rxd_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] shift_out = 8'h00;
	logic [7:0] shift_in = 8'h00;
	int left = 0;
	initial rxd_o = 1'b1;
	task load(input logic [7:0] d);
		shift_out = d;
		left = 8;
	endtask
	// New bit at each falling shift clock edge
	always @(negedge txd_i) begin
		if (!rxd_oe_i && left > 0) begin
			rxd_o <= shift_out[0];
			shift_out <= shift_out >> 1;
			left--;
		end
	end
	always @(posedge txd_i) begin
		if (rxd_oe_i)
			shift_in <= {rxd_i, shift_in[7:1]};
		else if (left == 0)
			rxd_o <= 1'b1;
	end
	task send(input logic [9:0] f, input int c);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			rxd_o <= f[i];
			repeat (c - 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		rxd_o <= 1'b1;
	endtask
	// Start too short to survive the vote
	task glitch;
		@(posedge clk_i);
		rxd_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		rxd_o <= 1'b1;
		repeat (30) @(posedge clk_i);
	endtask
endmodule

// ---- bench/serial_port_mode0_mode1_test.sv ----
// Self-checking bench of the serial port, both modes.
// Assumes a zero-wait bus slave and the peer on the pins.
module serial_port_mode0_mode1_test;
	timeunit 1ns;
	timeprecision 1ns;
	import serial_port_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready;
	logic rxd_o;
	logic rxd_oe_o;
	logic txd_o;
	logic peer_rxd;
	logic [31:0] rdat;
	int failures = 0;
	int num_checks = 0;
	wire logic rxd_line = rxd_oe_o ? rxd_o : peer_rxd;
	always #10 clk_i = ~clk_i;
	serial_port dut_u (.clk_i, .rst_i, .hsel_i(1'b1), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(HSIZE_WORD),
		.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(), .rxd_i(rxd_line), .rxd_o,
		.rxd_oe_o, .txd_o);
	serial_peer peer_u (.clk_i, .txd_i(txd_o), .rxd_oe_i(rxd_oe_o),
		.rxd_i(rxd_line), .rxd_o(peer_rxd));
	task tick;
		@(posedge clk_i);
		#1;
	endtask
	task check_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task check_count(input int got, input int exp);
		num_checks++;
		if (got != exp) begin
			failures++;
			$display("unexpected at %0t: count %0d want %0d", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk_i);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_i); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task poll(input int b);
		repeat (100) begin
			bus(1'b0, ADDR_SERIAL_CONTROL, 32'h0, rdat);
			if (rdat[b] === 1'b1)
				return;
		end
	endtask
	task m0_tx(input logic fast);
		int n;
		int low;
		bus(1'b1, ADDR_SERIAL_CONTROL, {26'h0, fast, 5'h0}, rdat);
		bus(1'b1, ADDR_SERIAL_BUFFER, 32'h96, rdat);
		@(posedge rxd_oe_o);
		n = 0;
		low = 0;
		fork
			while (rxd_oe_o) begin
				tick();
				n++;
			end
			begin
				@(negedge txd_o);
				while (!txd_o) begin
					tick();
					low++;
				end
			end
		join
		check_count(n, fast ? 32 : 96);
		check_count(low, fast ? 2 : 6);
		check_word(peer_u.shift_in, 32'h96);
		poll(1);
		check_word(rdat[1], 32'h1);
	endtask
	task m0_rx;
		int n;
		peer_u.load(8'h3c);
		bus(1'b1, ADDR_SERIAL_CONTROL, 32'h10, rdat);
		poll(0);
		check_word(rdat[0], 32'h1);
		bus(1'b0, ADDR_SERIAL_BUFFER, 32'h0, rdat);
		check_word(rdat, 32'h3c);
		n = 0;
		repeat (300) begin
			tick();
			if (!txd_o)
				n++;
		end
		check_count(n, 0);
	endtask
	task m1_tx;
		logic [9:0] f;
		bus(1'b1, ADDR_SERIAL_CONTROL, 32'h80, rdat);
		tick();
		check_word(txd_o, 32'h1);
		bus(1'b1, ADDR_SERIAL_BUFFER, 32'h5a, rdat);
		@(negedge txd_o);
		repeat (8) tick();
		for (int i = 0; i < 10; i++) begin
			f[i] = txd_o;
			repeat (16) tick();
		end
		check_word(f, {1'b1, 8'h5a, 1'b0});
		poll(1);
		check_word(rdat[1], 32'h1);
	endtask
	task m1_rx(input logic [7:0] ctl, input logic [9:0] f, input int c,
		input logic g, input logic ok);
		bus(1'b1, ADDR_SERIAL_CONTROL, {24'h0, ctl}, rdat);
		if (g)
			peer_u.glitch();
		peer_u.send(f, c);
		repeat (4) tick();
		bus(1'b0, ADDR_SERIAL_CONTROL, 32'h0, rdat);
		check_word(rdat[0], ok);
		if (ok) begin
			check_word(rdat[2], f[9]);
			bus(1'b0, ADDR_SERIAL_BUFFER, 32'h0, rdat);
			check_word(rdat, f[8:1]);
		end
	endtask
	task end_sim;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#400000;
		failures++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, 8'h0c, 32'h0, rdat);
		check_word(rdat, 32'h0);
		bus(1'b0, ADDR_SERIAL_CONTROL, 32'h0, rdat);
		check_word(rdat, 32'h0);
		m0_tx(1'b1);
		m0_tx(1'b0);
		m0_rx();
		m1_tx();
		m1_rx(8'h90, {1'b1, 8'hc3, 1'b0}, 16, 1'b0, 1'b1);
		m1_rx(8'hb0, {1'b0, 8'h3a, 1'b0}, 16, 1'b0, 1'b0);
		m1_rx(8'hb0, {1'b1, 8'h81, 1'b0}, 16, 1'b1, 1'b1);
		bus(1'b1, ADDR_BAUD_CONTROL, 32'h100, rdat);
		m1_rx(8'h90, {1'b1, 8'h6e, 1'b0}, 32, 1'b0, 1'b1);
		end_sim();
	end
endmodule
